/* design/timer_pkg.sv */
`default_nettype none
package timer_pkg;

  // ****************************************************************
  // device register map, 16-bit registers on the link
  // ****************************************************************
  localparam logic [15:0] CLOCK_SELECT_OFFSET = 16'h4200;
  localparam logic [15:0] RELOAD_OFFSET = 16'h4202;
  localparam logic [15:0] COUNT_OFFSET = 16'h4204;
  localparam logic [15:0] CONTROL_OFFSET = 16'h4206;

  // ****************************************************************
  // device field positions and reset values
  // ****************************************************************
  localparam int RUN_BIT = 0;
  localparam int PRESET_BIT = 1;
  localparam int MODE_BIT = 4;
  localparam logic [3:0] DIVIDER_RESERVED = 4'hf;
  localparam logic [3:0] DIVIDER_RESET = 4'h0;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic MODE_RESET = 1'b0;
  localparam logic RUN_RESET = 1'b0;
  localparam int PRESCALE_TAPS = 15;

  // ****************************************************************
  // host wishbone register map, byte addresses of 32-bit words
  // ****************************************************************
  localparam logic [7:0] HOST_LINK_ADDR_OFFSET = 8'h00;
  localparam logic [7:0] HOST_LINK_WRITE_OFFSET = 8'h04;
  localparam logic [7:0] HOST_LINK_READ_OFFSET = 8'h08;
  localparam logic [7:0] HOST_CONTROL_OFFSET = 8'h0c;
  localparam logic [7:0] HOST_IRQ_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] HOST_IRQ_CLEAR_OFFSET = 8'h14;
  localparam logic [7:0] HOST_IRQ_ENABLE_OFFSET = 8'h18;
  localparam int LINK_BUSY_BIT = 16;
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int IRQ_BAUD_BIT = 1;
  localparam logic [3:0] UART_DIVIDE_LAST = 4'hf;

endpackage
`default_nettype wire

/* design/timer_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface timer_link_if (
  input wire logic clk_i
);
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic reg_ack;
  logic [timer_pkg::PRESCALE_TAPS-1:0] prescale_en;
  logic underflow;

  modport device (
    input reg_addr, reg_wdata, reg_wr, reg_rd, prescale_en,
    output reg_rdata, reg_ack, underflow
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, prescale_en,
    input reg_rdata, reg_ack, underflow
  );
endinterface
`default_nettype wire

/* design/clock_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
module clock_prescaler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic [timer_pkg::PRESCALE_TAPS-1:0] tap_en_o
);
  typedef struct packed {
    logic [timer_pkg::PRESCALE_TAPS-2:0] cnt;
  } prescaler_s;

  prescaler_s state;
  prescaler_s next_state;

  // free counter, held at zero while stopped so every tap restarts aligned
  always_comb begin
    next_state = state;
    if (run_i) begin
      next_state.cnt = state.cnt + (timer_pkg::PRESCALE_TAPS - 1)'(1'b1);
    end else begin
      next_state.cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // tap 0 is every cycle; tap k fires once every 2**k cycles
  assign tap_en_o[0] = run_i;
  genvar k;
  generate
    for (k = 1; k < timer_pkg::PRESCALE_TAPS; k++) begin : g_tap
      assign tap_en_o[k] = run_i & (&state.cnt[k-1:0]);
    end
  endgenerate
endmodule
`default_nettype wire

/* design/reload_down_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module reload_down_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  timer_link_if.device link,
  output logic [7:0] count_o,
  output logic running_o,
  output logic underflow_o
);
  // ****************************************************************
  // register map and limitations
  // ****************************************************************
  // clock select, bits 3:0: picks prescaler tap n, a count tick every
  //   2**n clocks; the top code is reserved and gives no ticks at all
  // reload value, bits 7:0: preset for the counter on underflow or on
  //   a preset strobe; upper bits are dropped on write, read as zero
  // count, bits 7:0: live counter value, read only, writes are ignored
  // control: bit 0 run, bit 1 preset strobe, bit 4 one-shot mode; the
  //   strobe has no storage behind it, so it always reads back zero
  // any other offset is ignored on write and reads as zero
  //
  // after reset: tap zero, reload zero, count zero, repeat mode, stopped,
  //   and no answer pending on the link
  //
  // the gap between underflows is reload plus one ticks of the chosen
  //   tap, so a reload of zero gives an underflow on every tick
  // the tap and the mode are not guarded against change while running:
  //   the period after such a change can come out short or long, which
  //   is why software stops the timer before touching either
  // the run bit gates ticks only; stopping keeps the count, and a new
  //   start resumes from it unless a preset came in between
  // a preset strobe loads the count whether the timer runs or not; the
  //   same control write sets run from bit 0, so counting goes on only if that bit is set
  // after a one-shot underflow the count already holds the reload value,
  //   so setting run again starts a full period with no preset needed
  // the underflow pulse is one clock wide rather than one count period,
  //   so the host can count pulses without an edge detector of its own
  // every link request is answered one clock later, mapped or not, so
  //   the host never waits on an address that nothing decodes

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    // software settings
    logic [3:0] count_clock_divider_select;
    logic [7:0] reload_value;
    logic count_mode_select;
    logic run_control;
    // counter and its underflow pulse
    logic [7:0] count;
    logic underflow;
    // link answer
    logic [15:0] rdata;
    logic ack;
  } timer_s;

  // state is one packed record; next_state is its combinational copy
  timer_s state;
  timer_s next_state;
  // decode helpers, all combinational
  logic count_tick;
  logic preset_write;
  logic control_write;
  logic counting;
  logic at_zero;

  // ****************************************************************
  // count clock and register decode
  // ****************************************************************
  // the reserved select value gives no ticks at all, so the counter freezes
  assign count_tick = (state.count_clock_divider_select != timer_pkg::DIVIDER_RESERVED)
    && link.prescale_en[state.count_clock_divider_select];
  // write and preset decode for the control register
  assign control_write = link.reg_wr && (link.reg_addr == timer_pkg::CONTROL_OFFSET);
  assign preset_write = control_write && link.reg_wdata[timer_pkg::PRESET_BIT];
  // a tick only matters while running; ticks seen while stopped are lost
  assign counting = state.run_control && count_tick;
  // the counter passes below zero on a tick taken while it holds zero
  assign at_zero = state.count == 8'h00;

  // one underflow, with the selected tap high in cycle c0:
  //   c0  run set, count zero, tick high
  //   c1  underflow high for this clock only, count holds the reload
  //       value, and in one-shot mode run has already dropped
  //   c2  underflow low again, the host has latched its status bit
  // one link access:
  //   c0  the host raises write or read with address and data
  //   c1  ack high for one clock, a write has landed, rdata stands
  //   c2  ack low, rdata keeps its value until the next read
  //
  // order inside one clock, lowest first: a tick decrements or reloads;
  //   a register write then replaces that field; a preset strobe last
  //   overrides the count; so a run write that lands with the one-shot
  //   stop keeps the timer running, and a preset beats a decrement

  // one process for writes, counting and read answers
  always_comb begin
    next_state = state;
    next_state.underflow = 1'b0;
    next_state.ack = link.reg_wr || link.reg_rd;
    // counting comes first so that a register write in the same cycle wins
    if (counting) begin
      if (at_zero) begin
        next_state.underflow = 1'b1;
        next_state.count = state.reload_value;
        if (state.count_mode_select) begin
          next_state.run_control = 1'b0;
        end
      end else begin
        next_state.count = state.count - 8'h01;
      end
    end
    // host writes; unmapped offsets fall through untouched
    if (link.reg_wr) begin
      case (link.reg_addr)
        timer_pkg::CLOCK_SELECT_OFFSET: begin
          next_state.count_clock_divider_select = link.reg_wdata[3:0];
        end
        timer_pkg::RELOAD_OFFSET: begin
          next_state.reload_value = link.reg_wdata[7:0];
        end
        timer_pkg::CONTROL_OFFSET: begin
          next_state.count_mode_select = link.reg_wdata[timer_pkg::MODE_BIT];
          next_state.run_control = link.reg_wdata[timer_pkg::RUN_BIT];
        end
        default: begin
        end
      endcase
    end
    // preset is a control write, so run still takes bit 0 of the same write
    if (preset_write) begin
      next_state.count = state.reload_value;
    end
    // rdata is only refreshed by a read, so it stands until the next one
    // read answer; unmapped addresses read as zero
    if (link.reg_rd) begin
      case (link.reg_addr)
        timer_pkg::CLOCK_SELECT_OFFSET: begin
          next_state.rdata = {12'h000, state.count_clock_divider_select};
        end
        timer_pkg::RELOAD_OFFSET: begin
          next_state.rdata = {8'h00, state.reload_value};
        end
        timer_pkg::COUNT_OFFSET: begin
          next_state.rdata = {8'h00, state.count};
        end
        timer_pkg::CONTROL_OFFSET: begin
          next_state.rdata = {11'h000, state.count_mode_select, 2'b00,
            1'b0, state.run_control};
        end
        default: begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // one flop bank for the whole record keeps the update in one place;
  // synchronous reset returns each setting and the count to its named reset value, and clears underflow, rdata and ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.count_clock_divider_select <= timer_pkg::DIVIDER_RESET;
      state.reload_value <= timer_pkg::RELOAD_RESET;
      state.count_mode_select <= timer_pkg::MODE_RESET;
      state.run_control <= timer_pkg::RUN_RESET;
      state.count <= timer_pkg::COUNT_RESET;
      state.underflow <= 1'b0;
      state.rdata <= 16'h0000;
      state.ack <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs, all straight from state flops
  // ****************************************************************
  // link answers
  assign link.reg_rdata = state.rdata;
  assign link.reg_ack = state.ack;
  assign link.underflow = state.underflow;
  // local status pins, mirrors of the same flops
  assign count_o = state.count;
  assign running_o = state.run_control;
  assign underflow_o = state.underflow;
endmodule
`default_nettype wire

/* design/timer_host.sv */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module timer_host (
  input wire logic clk_i,
  input wire logic rst_i,
  timer_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic baud_tick_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [15:0] link_addr;
    logic [15:0] link_wdata;
    logic link_wr;
    logic link_rd;
    logic busy;
    logic [15:0] link_rdata;
    logic prescaler_run;
    logic [1:0] irq_status;
    logic [1:0] irq_enable;
    logic irq;
    logic [3:0] uart_div;
    logic baud_tick;
  } host_s;

  host_s state;
  host_s next_state;
  logic [timer_pkg::PRESCALE_TAPS-1:0] taps;
  logic bus_req;
  logic bus_write;
  logic [1:0] events;
  logic [1:0] clear_bits;

  // prescaler feeding the timer its count clock choices
  clock_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state.prescaler_run),
    .tap_en_o(taps)
  );

  assign bus_req = wb_cyc_i && wb_stb_i;
  // a write acts only at the edge where the master sees ack high
  assign bus_write = bus_req && wb_we_i && state.ack && wb_sel_i[0];
  assign clear_bits = (bus_write && wb_adr_i == timer_pkg::HOST_IRQ_CLEAR_OFFSET)
    ? wb_dat_i[1:0] : 2'b00;
  // sixteenth underflow makes one uart sampling tick
  assign events = {link.underflow && state.uart_div == timer_pkg::UART_DIVIDE_LAST,
    link.underflow};

  always_comb begin
    next_state = state;
    next_state.ack = bus_req && !state.ack;
    next_state.link_wr = 1'b0;
    next_state.link_rd = 1'b0;
    next_state.baud_tick = events[timer_pkg::IRQ_BAUD_BIT];
    if (link.underflow) begin
      next_state.uart_div = state.uart_div + 4'h1;
    end
    // read data is fetched as ack is raised
    if (bus_req && !state.ack) begin
      case (wb_adr_i)
        timer_pkg::HOST_LINK_ADDR_OFFSET: next_state.dat = {16'h0000, state.link_addr};
        timer_pkg::HOST_LINK_READ_OFFSET: next_state.dat = {15'h0000, state.busy,
          state.link_rdata};
        timer_pkg::HOST_CONTROL_OFFSET: next_state.dat = {31'h0000_0000,
          state.prescaler_run};
        timer_pkg::HOST_IRQ_STATUS_OFFSET: next_state.dat = {30'h0000_0000,
          state.irq_status};
        timer_pkg::HOST_IRQ_ENABLE_OFFSET: next_state.dat = {30'h0000_0000,
          state.irq_enable};
        default: next_state.dat = 32'h0000_0000;
      endcase
    end
    // link commands are dropped while one is outstanding
    if (bus_write) begin
      case (wb_adr_i)
        timer_pkg::HOST_LINK_ADDR_OFFSET: next_state.link_addr = wb_dat_i[15:0];
        timer_pkg::HOST_LINK_WRITE_OFFSET: begin
          if (!state.busy) begin
            next_state.link_wdata = wb_dat_i[15:0];
            next_state.link_wr = 1'b1;
            next_state.busy = 1'b1;
          end
        end
        timer_pkg::HOST_LINK_READ_OFFSET: begin
          if (!state.busy) begin
            next_state.link_rd = 1'b1;
            next_state.busy = 1'b1;
          end
        end
        timer_pkg::HOST_CONTROL_OFFSET: next_state.prescaler_run = wb_dat_i[0];
        timer_pkg::HOST_IRQ_ENABLE_OFFSET: next_state.irq_enable = wb_dat_i[1:0];
        default: begin
        end
      endcase
    end
    if (link.reg_ack) begin
      next_state.busy = 1'b0;
      next_state.link_rdata = link.reg_rdata;
    end
    // an event in the clearing cycle survives the clear
    next_state.irq_status = (state.irq_status & ~clear_bits) | events;
    next_state.irq = |(next_state.irq_status & next_state.irq_enable);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_ack_o = state.ack;
  assign wb_dat_o = state.dat;
  assign irq_o = state.irq;
  assign baud_tick_o = state.baud_tick;
  assign link.reg_addr = state.link_addr;
  assign link.reg_wdata = state.link_wdata;
  assign link.reg_wr = state.link_wr;
  assign link.reg_rd = state.link_rd;
  assign link.prescale_en = taps;
endmodule
`default_nettype wire

/* test/timer_link_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_link_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic [timer_pkg::PRESCALE_TAPS-1:0] prescale_en,
  input wire logic underflow
);
  logic run;
  logic mode;
  logic [7:0] reload;
  logic eff_run;
  logic [3:0] sel;
  logic sel_tick;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // one-shot drops run at the underflow edge, one cycle before the shadow sees it
  assign eff_run = run && !(underflow && mode);
  // enable of the tap that the shadow select names; the reserved code has none
  assign sel_tick = (sel == timer_pkg::DIVIDER_RESERVED) ? 1'b0 : prescale_en[sel];
  // shadow of what the host wrote; a write in the same cycle wins over the stop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'b0;
      mode <= 1'b0;
      reload <= 8'h00;
      sel <= timer_pkg::DIVIDER_RESET;
    end else if (reg_wr && reg_addr == timer_pkg::CONTROL_OFFSET) begin
      run <= reg_wdata[timer_pkg::RUN_BIT];
      mode <= reg_wdata[timer_pkg::MODE_BIT];
    end else begin
      run <= eff_run;
      if (reg_wr && reg_addr == timer_pkg::RELOAD_OFFSET) begin
        reload <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == timer_pkg::CLOCK_SELECT_OFFSET) begin
        sel <= reg_wdata[3:0];
      end
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_ack_one_later: assert property ((reg_wr || reg_rd) |=> reg_ack ##1 !reg_ack)
    else $error("link ack not one cycle after request");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("link ack without request");
  a_preset_reads_zero: assert property ((reg_rd && reg_addr == timer_pkg::CONTROL_OFFSET)
    |=> !reg_rdata[timer_pkg::PRESET_BIT])
    else $error("preset bit read back as one");
  a_divider_top_zero: assert property (
    (reg_rd && reg_addr == timer_pkg::CLOCK_SELECT_OFFSET) |=> reg_rdata[15:4] == 12'h000)
    else $error("clock select upper bits not zero");
  a_reload_read_back: assert property ((reg_rd && reg_addr == timer_pkg::RELOAD_OFFSET)
    |=> reg_rdata == {8'h00, $past(reload)})
    else $error("reload value read back wrong");
  a_control_read_back: assert property ((reg_rd && reg_addr == timer_pkg::CONTROL_OFFSET)
    |=> reg_rdata[timer_pkg::RUN_BIT] == $past(eff_run)
    && reg_rdata[timer_pkg::MODE_BIT] == $past(mode))
    else $error("run or mode read back wrong");
  a_underflow_on_tick: assert property (underflow |-> $past(sel_tick))
    else $error("underflow without a tick of the selected tap");
  a_underflow_when_run: assert property (underflow |-> $past(eff_run))
    else $error("underflow while stopped");
  c_one_shot_end: cover property (underflow && mode);
  c_preset_running: cover property (reg_wr && reg_wdata[timer_pkg::PRESET_BIT] && run);
  c_repeat_pair: cover property (underflow && !mode ##[1:200] underflow);
endmodule
`default_nettype wire

/* test/test_reload_down_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module test_reload_down_timer;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0000_0000;
  logic [31:0] dat_r;
  logic ack;
  logic irq;
  logic baud;
  logic uflow;
  logic [7:0] count;
  logic running;
  logic [31:0] rd;
  logic [31:0] held;
  logic [15:0] regs[5] = '{16'h4200, 16'h4202, 16'h4204, 16'h4206, 16'h4208};
  int miscompares = 0;
  int checks_done = 0;
  int seed = 68975;
  int uf_n = 0;
  int baud_n = 0;
  int r;
  time uf_t[$];
  timer_link_if link (.clk_i(clk_i));
  timer_host i_timer_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq), .baud_tick_o(baud));
  reload_down_timer i_reload_down_timer (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .count_o(count), .running_o(running), .underflow_o(uflow));
  timer_link_sva i_timer_link_sva (.clk_i(clk_i), .rst_i(rst_i), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack), .prescale_en(link.prescale_en),
    .underflow(link.underflow));
  // ****************************************************************
  // clock, model of underflow times, watchdog
  // ****************************************************************
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (uflow === 1'b1) uf_t.push_back($time);
    if (uflow === 1'b1) uf_n++;
    if (baud === 1'b1) baud_n++;
  end
  // the whole run needs well under 20000 cycles
  initial begin
    repeat (60000) @(posedge clk_i);
    $display("ERROR %0t: watchdog expired", $time);
    miscompares++;
    wrap_up();
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // classic cycle: held until ack is sampled, then one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk_i);
    // no answer time is assumed; only the watchdog ends a hung wait
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // device register access through the host, polling busy until it clears
  task dev(input logic w, input logic [15:0] a, input logic [15:0] d);
    wb(1'b1, timer_pkg::HOST_LINK_ADDR_OFFSET, {16'h0000, a});
    wb(1'b1, w ? timer_pkg::HOST_LINK_WRITE_OFFSET : timer_pkg::HOST_LINK_READ_OFFSET,
      {16'h0000, d});
    rd = 32'h0001_0000;
    while (rd[16] !== 1'b0) begin
      wb(1'b0, timer_pkg::HOST_LINK_READ_OFFSET, 32'h0);
    end
  endtask
  task wait_uf(input int k);
    repeat (5000) if (uf_t.size() < k) @(posedge clk_i);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // reset values, unmapped device and host places read zero
    foreach (regs[i]) begin
      dev(1'b0, regs[i], 16'h0);
      check(rd[15:0], 32'h0);
    end
    wb(1'b0, 8'h1c, 32'h0);
    check(rd, 32'h0);
    dev(1'b1, 16'h4200, 16'hfff5);
    dev(1'b0, 16'h4200, 16'h0);
    check(rd[15:0], 32'h5);
    dev(1'b1, 16'h4206, 16'h0012);
    dev(1'b0, 16'h4206, 16'h0);
    check(rd[15:0], 32'h10);
    $display("registers done");
    // repeat mode period for four dividers with random reloads
    wb(1'b1, timer_pkg::HOST_CONTROL_OFFSET, 32'h1);
    wb(1'b1, timer_pkg::HOST_IRQ_ENABLE_OFFSET, 32'h1);
    for (int div = 0; div < 4; div++) begin
      r = $random(seed) & 15;
      dev(1'b1, 16'h4200, 16'(div));
      dev(1'b1, 16'h4202, 16'(r));
      dev(1'b1, 16'h4206, 16'h0002);
      dev(1'b0, 16'h4204, 16'h0);
      check(rd[15:0], 32'(r));
      uf_t.delete();
      dev(1'b1, 16'h4206, 16'h0001);
      wait_uf(3);
      check(running, 1'b1);
      check(32'(uf_t[1] - uf_t[0]), 32'(((r + 1) << div) * 20));
      check(32'(uf_t[2] - uf_t[1]), 32'(((r + 1) << div) * 20));
      dev(1'b1, 16'h4206, 16'h0003);
      dev(1'b0, 16'h4206, 16'h0);
      check(rd[15:0], 32'h1);
      dev(1'b1, 16'h4206, 16'h0000);
      dev(1'b0, 16'h4204, 16'h0);
      held = rd;
      repeat (60) @(posedge clk_i);
      dev(1'b0, 16'h4204, 16'h0);
      check(rd, held);
      check(count, held[7:0]);
    end
    check(irq, 1'b1);
    wb(1'b1, timer_pkg::HOST_IRQ_CLEAR_OFFSET, 32'h3);
    wb(1'b0, timer_pkg::HOST_IRQ_STATUS_OFFSET, 32'h0);
    check(rd, 32'h0);
    check(irq, 1'b0);
    $display("repeat mode done");
    // one-shot: a single underflow with the interrupt masked
    wb(1'b1, timer_pkg::HOST_IRQ_ENABLE_OFFSET, 32'h0);
    dev(1'b1, 16'h4202, 16'h0005);
    dev(1'b1, 16'h4200, 16'h0001);
    dev(1'b1, 16'h4206, 16'h0012);
    uf_t.delete();
    dev(1'b1, 16'h4206, 16'h0011);
    repeat (300) @(posedge clk_i);
    check(uf_t.size(), 32'h1);
    check(running, 1'b0);
    check(count, 8'h05);
    dev(1'b0, 16'h4206, 16'h0);
    check(rd[15:0], 32'h10);
    dev(1'b0, 16'h4204, 16'h0);
    check(rd[15:0], 32'h5);
    wb(1'b0, timer_pkg::HOST_IRQ_STATUS_OFFSET, 32'h0);
    check(rd[0], 1'b1);
    check(irq, 1'b0);
    $display("one-shot done");
    // reserved divider gives no count ticks
    dev(1'b1, 16'h4206, 16'h0000);
    dev(1'b1, 16'h4200, 16'h000f);
    uf_t.delete();
    dev(1'b1, 16'h4206, 16'h0001);
    repeat (200) @(posedge clk_i);
    check(uf_t.size(), 32'h0);
    check(count, 8'h05);
    dev(1'b1, 16'h4206, 16'h0000);
    check(baud_n, uf_n / 16);
    $display("divider and baud done");
    wrap_up();
  end
endmodule
`default_nettype wire
